/* rtl/btob_core.sv */
// Executor for bit-toggle and branch-on-overflow, sequenced over four phases
// Summary of operation
// [RQ1] Toggle reads the addressed register, flips one bit, writes it back.
// [RQ2] Bank bit zero uses the access bank; one uses the bank select value.
// [RQ3] Three-bit position picks one of bits 0 through 7.
// [RQ4] Branch changes PC only when overflow is one: PC plus two plus 2n.
// [RQ5] Offset is signed eight-bit, doubled, added to incremented PC.
// [RQ6] Toggle prefix is four bits; overflow branch prefix is eight bits.
`timescale 1ns/100ps
`default_nettype none
module btob_core
   import btob_pkg::*;
(
   input  wire logic                  ref_clk,
   input  wire logic                  rst,
   input  wire logic [INSTR_W-1:0]    instr,
   input  wire logic                  instr_valid,
   input  wire logic [3:0]            bank_select_value,
   input  wire logic                  ovf_flag,
   input  wire logic [DATA_W-1:0]     rf_rdata,
   output logic      [ADDR_W-1:0]     rf_addr,
   output logic                       rf_rd,
   output logic                       rf_wr,
   output logic      [DATA_W-1:0]     rf_wdata,
   output logic      [PC_W-1:0]       pc,
   output logic                       flush,
   output logic                       busy
);
   // Decoded fields shared by decoder and executor
   btob_if fld ();

   // Sequencer and captured instruction state
   btob_phase_t        phase_reg;
   btob_phase_t        phase_next;
   logic [INSTR_W-1:0] ir_reg;
   logic               is_tog_reg;
   logic               is_ovf_br_reg;

   // Register file side state
   logic [ADDR_W-1:0]  addr_reg;
   logic               rd_reg;
   logic               wr_reg;
   logic [DATA_W-1:0]  data_reg;

   // Program flow state
   logic [PC_W-1:0]    pc_reg;
   logic               flush_reg;
   logic               busy_reg;

   // Phase decode and datapath nets
   wire logic              in_q1;
   wire logic              in_q2;
   wire logic              in_q3;
   wire logic              in_q4;
   wire logic              take_instr;
   wire logic              busy_next;
   wire logic [3:0]        acc_bank;
   wire logic [3:0]        bank;
   wire logic [ADDR_W-1:0] full_addr;
   wire logic [DATA_W-1:0] bit_mask;
   wire logic [DATA_W-1:0] toggled;
   wire logic [PC_W-1:0]   off2;
   wire logic [PC_W-1:0]   pc_incr;
   wire logic [PC_W-1:0]   target;
   wire logic [PC_W-1:0]   pc_next;
   wire logic              take;

   // True when a three-bit position names bit lane idx
   function automatic logic bit_hit(input logic [2:0] pos, input int idx);
      return (int'(pos) == idx);
   endfunction : bit_hit

   // Field decoder on the captured word
   btob_decode u_dec (
      .instr (ir_reg),
      .fld   (fld)
   );

   // Phase decode; a word is taken only in Q1
   assign in_q1      = (phase_reg == PH_Q1);
   assign in_q2      = (phase_reg == PH_Q2);
   assign in_q3      = (phase_reg == PH_Q3);
   assign in_q4      = (phase_reg == PH_Q4);
   assign take_instr = in_q1 & instr_valid;
   assign busy_next  = (phase_next != PH_Q1);

   // Bank resolution: access bank splits between low RAM and special registers
   assign acc_bank  = (fld.file_addr < ACCESS_SPLIT) ? ACCESS_BANK : SFR_BANK;
   assign bank      = fld.bank_sel ? bank_select_value : acc_bank; // [RQ2]
   assign full_addr = {bank, fld.file_addr};

   // Single-bit mask, one select per bit lane
   for (genvar i = 0; i < DATA_W; i++) begin : g_mask
      assign bit_mask[i] = bit_hit(fld.bit_pos, i); // [RQ3]
   end

   // Only the selected bit is inverted, the rest pass through
   assign toggled = rf_rdata ^ bit_mask; // [RQ1]

   // Signed offset doubled and sign-extended; target from the incremented PC
   assign off2    = {{(PC_W-9){fld.offset[7]}}, fld.offset, 1'b0}; // [RQ5]
   assign pc_incr = pc_reg + PC_STEP;
   assign target  = pc_incr + off2;                                 // [RQ5]
   assign take    = is_ovf_br_reg & ovf_flag;                       // [RQ4]
   assign pc_next = take ? target : pc_incr;                        // [RQ4]

   // Phase sequencer: Q1 take, Q2 decode, Q3 read and process, Q4 write
   always_comb begin
      unique case (phase_reg)
         PH_Q1: phase_next = instr_valid ? PH_Q2 : PH_Q1;
         PH_Q2: phase_next = PH_Q3;
         PH_Q3: phase_next = PH_Q4;
         PH_Q4: phase_next = PH_Q1;
      endcase
   end

   // Phase register
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         phase_reg <= PH_Q1;
      end else begin
         phase_reg <= phase_next;
      end
   end

   // Instruction word held for the whole instruction
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         ir_reg <= '0;
      end else if (take_instr) begin
         ir_reg <= instr;
      end
   end

   // Toggle flag: cleared on take, loaded from decode in Q2
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         is_tog_reg <= 1'b0;
      end else if (take_instr) begin
         is_tog_reg <= 1'b0;
      end else if (in_q2) begin
         is_tog_reg <= fld.is_toggle; // [RQ6]
      end
   end

   // Overflow branch flag: cleared on take, loaded from decode in Q2
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         is_ovf_br_reg <= 1'b0;
      end else if (take_instr) begin
         is_ovf_br_reg <= 1'b0;
      end else if (in_q2) begin
         is_ovf_br_reg <= fld.is_ovf_br; // [RQ6]
      end
   end

   // Read strobe, one cycle in Q3 of a toggle
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         rd_reg <= 1'b0;
      end else begin
         rd_reg <= in_q2 & fld.is_toggle; // [RQ1]
      end
   end

   // Write strobe, one cycle in Q4 of a toggle
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         wr_reg <= 1'b0;
      end else begin
         wr_reg <= in_q3 & is_tog_reg; // [RQ1]
      end
   end

   // Register address, fixed in Q2 so read and write share it
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         addr_reg <= '0;
      end else if (in_q2) begin
         addr_reg <= full_addr; // [RQ2]
      end
   end

   // Write data: read value with the one bit flipped
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         data_reg <= DATA_RESET;
      end else if (in_q3 && is_tog_reg) begin
         data_reg <= toggled; // [RQ1]
      end
   end

   // Program counter: advance by one word, or branch when overflow set
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         pc_reg <= PC_RESET;
      end else if (in_q4) begin
         pc_reg <= pc_next; // [RQ4]
      end
   end

   // Flush pulse for the cycle after a taken branch
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         flush_reg <= 1'b0;
      end else begin
         flush_reg <= in_q4 & take; // [RQ4]
      end
   end

   // Busy flag while an instruction occupies the phases
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         busy_reg <= 1'b0;
      end else begin
         busy_reg <= busy_next;
      end
   end

   // Outputs driven straight from their registers

   assign rf_addr  = addr_reg;
   assign rf_rd    = rd_reg;
   assign rf_wr    = wr_reg;
   assign rf_wdata = data_reg;
   assign pc       = pc_reg;
   assign flush    = flush_reg;
   assign busy     = busy_reg;
endmodule : btob_core
`default_nettype wire

/* rtl/btob_decode.sv */
// Instruction word decoder for the bit toggle and overflow branch
`timescale 1ns/100ps
`default_nettype none
module btob_decode
   import btob_pkg::*;
(
   input  wire logic [INSTR_W-1:0] instr,
   btob_if.dec                     fld
);
   // Field extraction from the fetched word
   assign fld.is_toggle = (instr[OPC_MSB:TOG_OPC_LSB] == TOGGLE_PREFIX); // [RQ6]
   assign fld.is_ovf_br = (instr[OPC_MSB:BR_OPC_LSB] == OVF_BR_PREFIX);  // [RQ6]
   assign fld.bit_pos   = instr[BIT_POS_MSB:BIT_POS_LSB];                // [RQ3]
   assign fld.bank_sel  = instr[BANK_BIT];                               // [RQ2]
   assign fld.file_addr = instr[FIELD_MSB:0];
   assign fld.offset    = instr[FIELD_MSB:0];                            // [RQ5]
endmodule : btob_decode
`default_nettype wire

/* rtl/btob_if.sv */
// Interface carrying decoded instruction fields between decoder and executor
`timescale 1ns/100ps
`default_nettype none
interface btob_if;
   logic       is_toggle;
   logic       is_ovf_br;
   logic [2:0] bit_pos;
   logic       bank_sel;
   logic [7:0] file_addr;
   logic [7:0] offset;
   modport dec (output is_toggle, is_ovf_br, bit_pos, bank_sel, file_addr, offset);
   modport exe (input is_toggle, is_ovf_br, bit_pos, bank_sel, file_addr, offset);
endinterface : btob_if
`default_nettype wire

/* rtl/btob_pkg.sv */
// Package with encodings, phase states and widths for the toggle/branch executor
package btob_pkg;
   localparam int          DATA_W        = 8;
   localparam int          ADDR_W        = 12;
   localparam int          PC_W          = 21;
   localparam int          INSTR_W       = 16;
   localparam int          OPC_MSB       = 15;
   localparam int          TOG_OPC_LSB   = 12;
   localparam int          BR_OPC_LSB    = 8;
   localparam int          BIT_POS_MSB   = 11;
   localparam int          BIT_POS_LSB   = 9;
   localparam int          BANK_BIT      = 8;
   localparam int          FIELD_MSB     = 7;
   localparam logic [3:0]  TOGGLE_PREFIX = 4'h7;
   localparam logic [7:0]  OVF_BR_PREFIX = 8'hE4;
   localparam logic [3:0]  ACCESS_BANK   = 4'h0;
   localparam logic [7:0]  ACCESS_SPLIT  = 8'h60;
   localparam logic [3:0]  SFR_BANK      = 4'hF;
   localparam logic [PC_W-1:0] PC_STEP   = 21'h000002;
   localparam logic [PC_W-1:0] PC_RESET  = 21'h000000;
   localparam logic [DATA_W-1:0] DATA_RESET = 8'h00;
   typedef enum logic [1:0] {
      PH_Q1,
      PH_Q2,
      PH_Q3,
      PH_Q4
   } btob_phase_t;
endpackage : btob_pkg

/* verif/bit_toggle_and_overflow_branch_bench.sv */
// Random and corner bench for the toggle/branch executor
`timescale 1ns/100ps
`default_nettype none
module bit_toggle_and_overflow_branch_bench;
   import btob_pkg::*;
   logic               ref_clk = 0, rst = 1, instr_valid = 0, ovf_flag = 0;
   logic               rf_rd, rf_wr, flush, busy;
   logic [INSTR_W-1:0] instr = 0;
   logic [3:0]         bank_select_value = 0;
   logic [DATA_W-1:0]  rf_rdata = 0, rf_wdata;
   logic [ADDR_W-1:0]  rf_addr;
   logic [PC_W-1:0]    pc, pc_m = 0;
   logic [31:0]        r = 32'h36E2;
   logic [15:0]        cw [8] = '{16'h7882, 16'h7E5F, 16'h7100, 16'hE480,
                                  16'hE47F, 16'hE47F, 16'h0000, 16'hE000};
   int                 n_fail = 0, total_checks = 0;
   btob_core dut_u (.*);
   // Clock at 200 MHz
   initial forever #2.5 ref_clk = ~ref_clk;
   function automatic logic [31:0] lfsr(input logic [31:0] v);
      return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction : lfsr
   task automatic chk(input string n, input logic [31:0] e, s);
      total_checks++;
      if (e !== s) begin
         n_fail++;
         $display("BAD %s expected %h seen %h", n, e, s);
      end
   endtask : chk
   task automatic end_of_test;
      $display("checks %0d mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : end_of_test
   // Expected write data and next pc
   function automatic logic [7:0] exp_flip(input logic [7:0] d, input logic [2:0] b);
      return d ^ (8'h01 << b);
   endfunction : exp_flip
   function automatic logic [PC_W-1:0] exp_pc(input logic [PC_W-1:0] p, input logic [15:0] w,
                                              input logic o);
      return p + PC_STEP + ((w[15:8] == OVF_BR_PREFIX && o) ?
                            {{12{w[7]}}, w[7:0], 1'b0} : 21'h000000);
   endfunction : exp_pc
   // One instruction: drive, then check read, write, busy and pc
   task automatic run(input logic [15:0] w, input logic o, input logic [7:0] d);
      logic tg, bv;
      logic [3:0] bk;
      tg = w[15:12] == TOGGLE_PREFIX;
      bv = w[15:8] == OVF_BR_PREFIX;
      bk = w[8] ? r[31:28] : ((w[7:0] < ACCESS_SPLIT) ? ACCESS_BANK : SFR_BANK);
      @(posedge ref_clk);
      instr <= w;
      instr_valid <= 1;
      ovf_flag <= o;
      rf_rdata <= d;
      bank_select_value <= r[31:28];
      @(posedge ref_clk);
      instr_valid <= 0;
      @(posedge ref_clk);
      #1;
      chk("rf_rd", tg, rf_rd);
      @(posedge ref_clk);
      #1;
      chk("rf_wr", tg, rf_wr);
      chk("busy", 1, busy);
      if (tg) chk("rf_wdata", exp_flip(d, w[11:9]), rf_wdata);
      if (tg) chk("rf_addr", {bk, w[7:0]}, rf_addr);
      @(posedge ref_clk);
      #1;
      pc_m = exp_pc(pc_m, w, o);
      chk("flush", bv && o, flush);
      chk("pc", pc_m, pc);
      chk("busy", 0, busy);
   endtask : run
   // Corner words, then biased random words
   initial begin
      repeat (12) @(posedge ref_clk);
      rst <= 0;
      foreach (cw[i]) run(cw[i], i != 5, 8'h75);
      repeat (40) begin
         r = lfsr(r);
         run(r[17:16] == 0 ? {TOGGLE_PREFIX, r[11:0]} :
             r[17:16] == 1 ? {OVF_BR_PREFIX, r[7:0]} : r[15:0], r[18], r[27:20]);
      end
      end_of_test();
   end
   // Hang guard
   initial begin
      #5000;
      n_fail++;
      end_of_test();
   end
endmodule : bit_toggle_and_overflow_branch_bench
`default_nettype wire

/* verif/btob_monitor.sv */
// Port checks for the toggle/branch executor
`timescale 1ns/100ps
`default_nettype none
module btob_monitor
   import btob_pkg::*;
(
   input wire logic                ref_clk,
   input wire logic                rst,
   input wire logic                instr_valid,
   input wire logic                ovf_flag,
   input wire logic                rf_rd,
   input wire logic                rf_wr,
   input wire logic                flush,
   input wire logic                busy,
   input wire logic [INSTR_W-1:0]  instr,
   input wire logic [3:0]          bank_select_value,
   input wire logic [DATA_W-1:0]   rf_rdata,
   input wire logic [DATA_W-1:0]   rf_wdata,
   input wire logic [ADDR_W-1:0]   rf_addr,
   input wire logic [PC_W-1:0]     pc
);
   logic [15:0]     iw;
   wire logic [3:0] acc = (iw[7:0] < ACCESS_SPLIT) ? ACCESS_BANK : SFR_BANK;
   // Word held from its take edge
   always_ff @(posedge ref_clk) if (instr_valid && !busy) iw <= instr;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst);
   sequence s_rw; rf_rd ##1 rf_wr; endsequence
   sequence s_busy_run; busy [*3] ##1 !busy; endsequence
   a_read_then_write: assert property (rf_rd |-> s_rw)
      else $error("write missing");
   a_write_same_reg: assert property (rf_wr |-> $past(rf_rd) && $stable(rf_addr))
      else $error("stray write");
   a_one_bit_flip: assert property (rf_wr |-> rf_wdata == ($past(rf_rdata) ^ (8'h01 << iw[11:9])))
      else $error("wrong write data");
   a_bank_choice: assert property (rf_rd |-> rf_addr == {iw[8] ? $past(bank_select_value) : acc, iw[7:0]})
      else $error("wrong address");
   a_toggle_decode: assert property (rf_rd |-> iw[15:12] == TOGGLE_PREFIX)
      else $error("read without toggle");
   a_flush_cause: assert property (flush |-> $past(ovf_flag) && iw[15:8] == OVF_BR_PREFIX)
      else $error("flush without cause");
   a_branch_target: assert property (flush |-> pc == $past(pc) + PC_STEP + {{12{iw[7]}}, iw[7:0], 1'b0})
      else $error("wrong target");
   a_busy_span: assert property (instr_valid && !busy |=> s_busy_run)
      else $error("busy span wrong");
   a_flush_single: assert property (flush |=> !flush)
      else $error("flush too long");
   a_pc_update_time: assert property ($changed(pc) |-> $past(busy) && !busy)
      else $error("pc moved mid instruction");
endmodule : btob_monitor
bind btob_core btob_monitor mon_u (.*);
`default_nettype wire
